/* File: src/lfwt_pkg.sv */
package lfwt_pkg;
    // ==========================================================
    // Register map (byte addresses; printed offsets are not all multiples of four)
    localparam logic [7:0] PWR_CTRL_IDX = 8'h87;
    localparam logic [7:0] TMR_CTRL_IDX = 8'hFB;
    localparam logic [7:0] WAKE_STAT_IDX = 8'hF0;
    localparam logic [11:0] PWR_CTRL_ADDR = {PWR_CTRL_IDX, 2'b00} + 12'h000;
    localparam logic [11:0] TMR_CTRL_ADDR = {TMR_CTRL_IDX, 2'b00} + 12'h000;
    localparam logic [11:0] WAKE_STAT_ADDR = {WAKE_STAT_IDX, 2'b00} + 12'h000;

    // ==========================================================
    // Field positions
    localparam int RUN_BIT = 7;
    localparam int FLAG_BIT = 6;
    localparam int SEL_LSB = 0;
    localparam int STOP_BIT = 1;
    localparam int IDLE_BIT = 0;

    // ==========================================================
    // Reset values
    localparam logic RUN_RST = 1'b0;
    localparam logic FLAG_RST = 1'b0;
    localparam logic [3:0] SEL_RST = 4'h0;

    // ==========================================================
    // Timing
    localparam int LF_HZ = 32000;
    localparam int BASE_TICKS = 500;    // 15.625 ms at 32 kHz
    localparam int CODE_4MS = 8;
    localparam int TICKS_4MS = 128;     // 4.0 ms as printed
    localparam int SYS_MHZ = 250;
    localparam int OSC_SETTLE_NS = 2000;
    localparam int OSC_SETTLE_CYC = (OSC_SETTLE_NS * SYS_MHZ + 999) / 1000;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {LFWT_RUN, LFWT_IDLE, LFWT_STOP, LFWT_WARM} lfwt_mode_t;

    typedef struct packed {
        logic run;
        logic [3:0] sel;
    } lfwt_tcfg_t;
endpackage : lfwt_pkg

/* File: src/lfwt_top.sv */
// Local design decision: the APB interface to the registers.
module lfwt_top #(
    parameter int SETTLE_CYC = lfwt_pkg::OSC_SETTLE_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Slow clock tick (pin domain) and oscillator control
    input wire logic lfTick,
    input wire logic watchdogEnable,
    output logic lfOscEnable,
    output logic hfOscEnable,
    // Interrupt system
    input wire logic [2:0] externalIrqInputs,
    input wire logic irqEnabledPending,
    input wire logic timerIrqAccept,
    output logic timerIrq,
    // Core hold
    output logic coreHold
);
    // ==========================================================
    // Input synchronisers
    logic [2:0] tickSync_reg, tickSync_next;
    logic [2:0] extS1_reg, extS1_next, extS2_reg, extS2_next;
    logic wdS1_reg, wdS1_next, wdS2_reg, wdS2_next;

    // Two flops per pin; the tick gets a third so its edge test never reads the first
    always_comb begin
        tickSync_next = {tickSync_reg[1:0], lfTick};
        extS1_next = externalIrqInputs;
        extS2_next = extS1_reg;
        wdS1_next = watchdogEnable;
        wdS2_next = wdS1_reg;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tickSync_reg <= 3'h0;
            extS1_reg <= 3'h0;
            extS2_reg <= 3'h0;
            wdS1_reg <= 1'b0;
            wdS2_reg <= 1'b0;
        end else begin
            tickSync_reg <= tickSync_next;
            extS1_reg <= extS1_next;
            extS2_reg <= extS2_next;
            wdS1_reg <= wdS1_next;
            wdS2_reg <= wdS2_next;
        end
    end

    // Edge only uses the second and third stages
    logic tickEdge;
    assign tickEdge = tickSync_reg[1] & ~tickSync_reg[2];

    // ==========================================================
    // APB decode
    logic wrEn, rdEn, hitPwr, hitTmr, hitStat;
    assign wrEn = psel & penable & pwrite;
    assign rdEn = psel & penable & ~pwrite;
    assign hitPwr = paddr == lfwt_pkg::PWR_CTRL_ADDR;
    assign hitTmr = paddr == lfwt_pkg::TMR_CTRL_ADDR;
    assign hitStat = paddr == lfwt_pkg::WAKE_STAT_ADDR;

    // ==========================================================
    // Timer state
    lfwt_pkg::lfwt_tcfg_t tcfg_reg, tcfg_next;
    logic flag_reg, flag_next;
    logic [20:0] tickCnt_reg, tickCnt_next;
    logic [20:0] period;
    logic elapsed;

    // Period in slow ticks; reserved codes never fire
    always_comb begin
        if (tcfg_reg.sel == 4'(lfwt_pkg::CODE_4MS)) begin
            period = 21'(lfwt_pkg::TICKS_4MS);
        end else if (tcfg_reg.sel > 4'hB) begin
            period = 21'h000000;
        end else begin
            period = 21'(lfwt_pkg::BASE_TICKS) << tcfg_reg.sel;
        end
    end

    assign elapsed = tcfg_reg.run && tickEdge && period != 21'h0 && tickCnt_reg + 21'h1 >= period;

    always_comb begin
        tcfg_next = tcfg_reg;
        flag_next = flag_reg;
        tickCnt_next = tickCnt_reg;
        if (wrEn && hitTmr) begin
            tcfg_next.run = pwdata[lfwt_pkg::RUN_BIT];
            tcfg_next.sel = pwdata[lfwt_pkg::SEL_LSB +: 4];
            flag_next = pwdata[lfwt_pkg::FLAG_BIT];
        end
        if (timerIrqAccept) begin
            flag_next = 1'b0;
        end
        // Count only while running; restart after each period
        if (!tcfg_reg.run) begin
            tickCnt_next = 21'h0;
        end else if (elapsed) begin
            tickCnt_next = 21'h0;
        end else if (tickEdge) begin
            tickCnt_next = tickCnt_reg + 21'h1;
        end
        // Set wins over any clear in the same cycle
        if (elapsed) begin
            flag_next = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tcfg_reg <= '{run: lfwt_pkg::RUN_RST, sel: lfwt_pkg::SEL_RST};
            flag_reg <= lfwt_pkg::FLAG_RST;
            tickCnt_reg <= 21'h0;
        end else begin
            tcfg_reg <= tcfg_next;
            flag_reg <= flag_next;
            tickCnt_reg <= tickCnt_next;
        end
    end

    // ==========================================================
    // Power modes
    lfwt_pkg::lfwt_mode_t mode_reg, mode_next;
    logic [15:0] settle_reg, settle_next;
    logic [1:0] wake_reg, wake_next;    // Last STOP wake cause: bit0 external, bit1 timer
    logic extWake;
    assign extWake = |extS2_reg;

    // Mode writes only act from RUN: a halted core cannot issue one
    always_comb begin
        mode_next = mode_reg;
        settle_next = settle_reg;
        wake_next = wake_reg;
        unique case (mode_reg)
            lfwt_pkg::LFWT_RUN: begin
                // Write only register: mode bits act, nothing is stored
                if (wrEn && hitPwr && pwdata[lfwt_pkg::STOP_BIT]) begin
                    mode_next = lfwt_pkg::LFWT_STOP;
                end else if (wrEn && hitPwr && pwdata[lfwt_pkg::IDLE_BIT]) begin
                    mode_next = lfwt_pkg::LFWT_IDLE;
                end
            end
            lfwt_pkg::LFWT_IDLE: begin
                if (irqEnabledPending || flag_reg) begin
                    mode_next = lfwt_pkg::LFWT_RUN;
                end
            end
            lfwt_pkg::LFWT_STOP: begin
                // Only external lines or the timer end STOP
                if (extWake || flag_reg) begin
                    mode_next = lfwt_pkg::LFWT_WARM;
                    settle_next = 16'(SETTLE_CYC);
                    wake_next = {flag_reg, extWake};
                end
            end
            lfwt_pkg::LFWT_WARM: begin
                // Hold the core until the fast oscillator settles
                if (settle_reg <= 16'h1) begin
                    mode_next = lfwt_pkg::LFWT_RUN;
                end else begin
                    settle_next = settle_reg - 16'h1;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_reg <= lfwt_pkg::LFWT_RUN;
            settle_reg <= 16'h0;
            wake_reg <= 2'h0;
        end else begin
            mode_reg <= mode_next;
            settle_reg <= settle_next;
            wake_reg <= wake_next;
        end
    end

    // ==========================================================
    // Registered outputs
    logic [31:0] prdata_next;
    logic pready_next, pslverr_next;
    logic lfOsc_next, hfOsc_next, irq_next, hold_next;

    // Oscillator, interrupt and hold outputs follow next state, so they change with the state and not a cycle later; the watchdog term follows wdS2_reg a cycle later
    always_comb begin
        prdata_next = 32'h0;
        pready_next = psel & ~penable;
        pslverr_next = 1'b0;
        if (psel && !penable) begin
            if (hitTmr && !pwrite) begin
                prdata_next = {24'h0, tcfg_reg.run, flag_reg, 2'b00, tcfg_reg.sel};
            end else if (hitStat && !pwrite) begin
                prdata_next = {30'h0, wake_reg};
            end else if (hitPwr) begin
                prdata_next = 32'h0;
                pslverr_next = ~pwrite;
            end else if (!hitTmr && !hitStat) begin
                pslverr_next = 1'b1;
            end else begin
                pslverr_next = pwrite & hitStat;
            end
        end
        lfOsc_next = tcfg_next.run | wdS2_reg;
        hfOsc_next = mode_next != lfwt_pkg::LFWT_STOP;
        irq_next = flag_next;
        hold_next = mode_next != lfwt_pkg::LFWT_RUN;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            lfOscEnable <= 1'b0;
            hfOscEnable <= 1'b1;
            timerIrq <= 1'b0;
            coreHold <= 1'b0;
        end else begin
            prdata <= prdata_next;
            pready <= pready_next;
            pslverr <= pslverr_next;
            lfOscEnable <= lfOsc_next;
            hfOscEnable <= hfOsc_next;
            timerIrq <= irq_next;
            coreHold <= hold_next;
        end
    end

    // ==========================================================
    // Checks
    // Timer
    flag_set_a: assert property (@(posedge clk) disable iff (rst) elapsed |=> flag_reg)
        else $error("flag not set after period");
    flag_clear_a: assert property (@(posedge clk) disable iff (rst)
        (timerIrqAccept && !elapsed && !(wrEn && hitTmr)) |=> !flag_reg)
        else $error("flag not cleared on accept");
    run_stop_a: assert property (@(posedge clk) disable iff (rst) !tcfg_reg.run |=> tickCnt_reg == 21'h0)
        else $error("counter moved while stopped");
    count_restart_a: assert property (@(posedge clk) disable iff (rst) elapsed |=> tickCnt_reg == 21'h0)
        else $error("counter not restarted");
    reserved_quiet_a: assert property (@(posedge clk) disable iff (rst) tcfg_reg.sel > 4'hB |-> !elapsed)
        else $error("reserved select fired");
    irq_follow_a: assert property (@(posedge clk) disable iff (rst)
        (flag_reg && !timerIrqAccept && !(wrEn && hitTmr)) |=> timerIrq)
        else $error("interrupt not raised");

    // Power modes
    stop_entry_a: assert property (@(posedge clk) disable iff (rst)
        (mode_reg == lfwt_pkg::LFWT_RUN && wrEn && hitPwr && pwdata[lfwt_pkg::STOP_BIT]) |=> !hfOscEnable)
        else $error("fast oscillator not halted");
    hf_stop_a: assert property (@(posedge clk) disable iff (rst)
        mode_reg == lfwt_pkg::LFWT_STOP |-> !hfOscEnable)
        else $error("fast oscillator running in STOP");
    stop_exit_a: assert property (@(posedge clk) disable iff (rst)
        (mode_reg == lfwt_pkg::LFWT_STOP && !extWake && !flag_reg) |=> mode_reg == lfwt_pkg::LFWT_STOP)
        else $error("STOP left without cause");
    wake_flag_a: assert property (@(posedge clk) disable iff (rst)
        (mode_reg == lfwt_pkg::LFWT_STOP && flag_reg) |=> mode_reg == lfwt_pkg::LFWT_WARM)
        else $error("timer did not end STOP");
    idle_wake_a: assert property (@(posedge clk) disable iff (rst)
        (mode_reg == lfwt_pkg::LFWT_IDLE && irqEnabledPending) |=> !coreHold)
        else $error("IDLE not ended");
    idle_hold_a: assert property (@(posedge clk) disable iff (rst)
        mode_reg == lfwt_pkg::LFWT_IDLE |-> coreHold && hfOscEnable)
        else $error("core not held in IDLE");
    warm_hold_a: assert property (@(posedge clk) disable iff (rst)
        $rose(mode_reg == lfwt_pkg::LFWT_WARM) |-> coreHold && hfOscEnable)
        else $error("core released too early");

    // Oscillators and bus
    lf_osc_a: assert property (@(posedge clk) disable iff (rst) tcfg_reg.run |-> lfOscEnable)
        else $error("slow oscillator off");
    lf_watch_a: assert property (@(posedge clk) disable iff (rst) wdS2_reg |=> lfOscEnable)
        else $error("slow oscillator off for watchdog");
    pwr_read_a: assert property (@(posedge clk) disable iff (rst)
        (psel && !penable && !pwrite && hitPwr) |=> prdata == 32'h0 && pslverr)
        else $error("power register readable");
endmodule : lfwt_top

/* File: dv/lfwt_top_bench.sv */
module lfwt_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================
    // Stimulus and bookkeeping
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic lfTick = 1'b0;
    logic watchdogEnable = 1'b0;
    logic [2:0] extIrq = 3'h0;
    logic irqPend = 1'b0;
    logic irqAccept = 1'b0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, lfOscEnable, hfOscEnable, timerIrq, coreHold, err;
    int badCount = 0;
    int testsRun = 0;
    int cycles = 0;
    int tickDiv = 0;
    int n;

    lfwt_top #(.SETTLE_CYC(5)) i_lfwt_top (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lfTick(lfTick),
        .watchdogEnable(watchdogEnable), .lfOscEnable(lfOscEnable), .hfOscEnable(hfOscEnable),
        .externalIrqInputs(extIrq), .irqEnabledPending(irqPend), .timerIrqAccept(irqAccept),
        .timerIrq(timerIrq), .coreHold(coreHold));

    // Clock, slow tick every four cycles, hang guard
    always #2 clk = ~clk;
    always @(posedge clk) begin
        tickDiv <= tickDiv + 1;
        lfTick <= tickDiv[1];
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            badCount++;
            testDone();
        end
    end

    // ==========================================================
    // Shared tasks
    task testDone();
        $display("Checks run %0d, mismatches %0d", testsRun, badCount);
        if (badCount == 0 && testsRun > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : testDone

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            badCount++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Gap cycle first, so psel is never driven twice in one step
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1); // Only the bench timeout ends a hang
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task waitFlag(input int lim);
        n = 0;
        while (timerIrq !== 1'b1 && n < lim) begin
            @(posedge clk);
            n++;
        end
    endtask : waitFlag

    task accept();
        irqAccept <= 1'b1;
        @(posedge clk);
        irqAccept <= 1'b0;
        repeat (2) @(posedge clk);
        chk(timerIrq, 1'b0);
    endtask : accept

    // ==========================================================
    // Scenarios
    task tResetRegs();
        chk({hfOscEnable, coreHold, lfOscEnable, timerIrq}, 4'h8);
        apb(1'b0, lfwt_pkg::TMR_CTRL_ADDR, 32'h0);
        chk(rd, 32'h0);
        chk(err, 1'b0);
        apb(1'b0, lfwt_pkg::PWR_CTRL_ADDR, 32'h0);
        chk(rd, 32'h0);
        chk(err, 1'b1);
        apb(1'b0, 12'h004, 32'h0);
        chk(err, 1'b1);
        apb(1'b1, lfwt_pkg::TMR_CTRL_ADDR, 32'h8B);
        apb(1'b0, lfwt_pkg::TMR_CTRL_ADDR, 32'h0);
        chk(rd, 32'h8B);
        chk(lfOscEnable, 1'b1);
        apb(1'b1, lfwt_pkg::TMR_CTRL_ADDR, 32'h0);
        watchdogEnable <= 1'b1;
        repeat (6) @(posedge clk);
        chk(lfOscEnable, 1'b1);
        watchdogEnable <= 1'b0;
        repeat (6) @(posedge clk);
        chk(lfOscEnable, 1'b0);
    endtask : tResetRegs

    // Flag to flag spacing is checked to within two cycles once the tick phase is locked
    task tPeriod(input logic [3:0] sel, input int ticks);
        apb(1'b1, lfwt_pkg::TMR_CTRL_ADDR, {24'h0, 4'h8, sel});
        waitFlag(ticks * 4 + 50);
        chk(timerIrq, 1'b1);
        accept();
        waitFlag(ticks * 4 + 50);
        chk((n + 3 >= ticks * 4 - 2) && (n + 3 <= ticks * 4 + 2), 1'b1);
        accept();
        apb(1'b1, lfwt_pkg::TMR_CTRL_ADDR, 32'h0);
    endtask : tPeriod

    task tIdle();
        apb(1'b1, lfwt_pkg::PWR_CTRL_ADDR, 32'h1);
        repeat (12) @(posedge clk);
        chk({coreHold, hfOscEnable}, 2'b11);
        irqPend <= 1'b1;
        repeat (3) @(posedge clk);
        chk(coreHold, 1'b0);
        irqPend <= 1'b0;
    endtask : tIdle

    task tStopExt();
        apb(1'b1, lfwt_pkg::PWR_CTRL_ADDR, 32'h2);
        repeat (12) @(posedge clk);
        chk({coreHold, hfOscEnable}, 2'b10);
        irqPend <= 1'b1;
        repeat (20) @(posedge clk);
        chk(hfOscEnable, 1'b0);
        irqPend <= 1'b0;
        extIrq <= 3'h4;
        n = 0;
        while (hfOscEnable !== 1'b1 && n < 10) begin
            @(posedge clk);
            n++;
        end
        chk({hfOscEnable, coreHold}, 2'b11);
        n = 0;
        while (coreHold !== 1'b0 && n < 20) begin
            @(posedge clk);
            n++;
        end
        chk(n >= 4 && n <= 7, 1'b1);
        extIrq <= 3'h0;
        apb(1'b0, lfwt_pkg::WAKE_STAT_ADDR, 32'h0);
        chk(rd, 32'h1);
    endtask : tStopExt

    task tStopTimer();
        apb(1'b1, lfwt_pkg::TMR_CTRL_ADDR, 32'h88);
        apb(1'b1, lfwt_pkg::PWR_CTRL_ADDR, 32'h2);
        repeat (12) @(posedge clk);
        chk(hfOscEnable, 1'b0);
        chk(lfOscEnable, 1'b1);
        waitFlag(700);
        repeat (3) @(posedge clk);
        chk(hfOscEnable, 1'b1);
        accept();
        repeat (10) @(posedge clk);
        apb(1'b1, lfwt_pkg::TMR_CTRL_ADDR, 32'h0);
        apb(1'b0, lfwt_pkg::WAKE_STAT_ADDR, 32'h0);
        chk(rd, 32'h2);
    endtask : tStopTimer

    // Reserved select never fires; reset ends STOP
    task tReservedAndReset();
        apb(1'b1, lfwt_pkg::TMR_CTRL_ADDR, 32'h8C);
        waitFlag(3000);
        chk(timerIrq, 1'b0);
        apb(1'b1, lfwt_pkg::PWR_CTRL_ADDR, 32'h2);
        repeat (12) @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({hfOscEnable, coreHold, lfOscEnable}, 3'b100);
    endtask : tReservedAndReset

    // ==========================================================
    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        tResetRegs();
        tPeriod(4'h8, lfwt_pkg::TICKS_4MS);
        tPeriod(4'h0, lfwt_pkg::BASE_TICKS);
        tPeriod(4'h1, lfwt_pkg::BASE_TICKS * 2);
        tIdle();
        tStopExt();
        tStopTimer();
        tReservedAndReset();
        testDone();
    end
endmodule : lfwt_top_bench
